/* File: tem_error_monitor.sv */
`timescale 1ns/1ps
module tem_error_monitor #(
  parameter int AIS_WINDOW = tem_pkg::AIS_WINDOW_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_cs_b,
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe_b,
  input wire logic i_rclk,
  input wire logic i_rx_positive_rail,
  input wire logic i_rx_negative_rail,
  input wire tem_pkg::tem_frm_type i_frm,
  output logic [7:0] o_rx_ctrl_one,
  output logic [7:0] o_rx_ctrl_two,
  output logic o_yellow_alarm_flag,
  output logic o_int_b
);
  import tem_pkg::*;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic sclk_prev;
  logic rclk_prev;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1 <= PIN_SYNC_RST;
      pin_s2 <= PIN_SYNC_RST;
      sclk_prev <= 1'b1;
      rclk_prev <= 1'b0;
    end else begin
      pin_s1 <= {i_cs_b, i_sclk, i_sdi, i_rclk, i_rx_positive_rail, i_rx_negative_rail};
      pin_s2 <= pin_s1;
      sclk_prev <= pin_s2[4];
      rclk_prev <= pin_s2[2];
    end
  end

  wire cs_b = pin_s2[5];
  wire sclk_rise = pin_s2[4] & ~sclk_prev;
  wire sclk_fall = ~pin_s2[4] & sclk_prev;
  wire sdi = pin_s2[3];
  wire bit_stb = pin_s2[2] & ~rclk_prev;

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  tem_sp_state_type state;
  logic [2:0] bit_cnt;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [3:0] addr;
  logic rw;
  logic burst;
  logic tx_load;

  wire [7:0] next_sh = {sdi, sh[7:1]};
  wire byte_done = sclk_rise & (bit_cnt == 3'h7);
  wire cmd_done = (state == SP_CMD) & byte_done & ~cs_b;
  wire data_done = (state == SP_DATA) & byte_done & ~cs_b;
  wire wr_stb = data_done & ~rw;
  wire rd_done = data_done & rw;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= SP_IDLE;
      bit_cnt <= 3'h0;
      sh <= RST_REG;
      addr <= REG_BPV_HIGH;
      rw <= 1'b0;
      burst <= 1'b0;
    end else if (cs_b) begin
      state <= SP_IDLE;
      bit_cnt <= 3'h0;
      burst <= 1'b0;
    end else begin
      if (state != SP_IDLE && sclk_rise) begin
        sh <= next_sh;
        bit_cnt <= bit_cnt + 3'h1;
      end
      unique case (state)
        SP_IDLE: state <= SP_CMD;
        SP_CMD: begin
          if (byte_done) begin
            rw <= next_sh[ACB_RW];
            addr <= next_sh[4:1];
            burst <= next_sh[ACB_BURST] & hit(next_sh[4:1], REG_BPV_HIGH);
            state <= SP_DATA;
          end
        end
        SP_DATA: begin
          if (byte_done && burst) begin
            addr <= addr + 4'h1;
          end
        end
      endcase
    end
  end

  wire [7:0] reg_view [0:15];
  wire [7:0] rd_data = reg_view[addr];

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_load <= 1'b0;
      tx <= RST_REG;
      o_sdo <= 1'b0;
      o_sdo_oe_b <= 1'b1;
    end else begin
      tx_load <= cmd_done | (data_done & burst);
      o_sdo_oe_b <= ~(~cs_b & (state == SP_DATA) & rw);
      if (tx_load) begin
        tx <= rd_data;
      end else if (sclk_fall && state == SP_DATA && rw && !cs_b) begin
        o_sdo <= tx[0];
        tx <= {1'b0, tx[7:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, mask and BPV storage
  // ----------------------------------------------------------------
  logic [7:0] mask_one;
  logic [7:0] mask_two;
  logic [15:0] bpv_count;
  logic [7:0] bpv_low_stage;

  wire esf = o_rx_ctrl_two[CTL_FORMAT];

  // The low byte waits in a stage so both halves of the BPV count change together.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_ctrl_one <= RST_REG;
      o_rx_ctrl_two <= RST_REG;
      mask_one <= RST_REG;
      mask_two <= RST_REG;
      bpv_count <= {RST_REG, RST_REG};
      bpv_low_stage <= RST_REG;
    end else begin
      if (wr_stb && hit(addr, REG_CTRL_ONE)) o_rx_ctrl_one <= next_sh;
      if (wr_stb && hit(addr, REG_CTRL_TWO)) o_rx_ctrl_two <= next_sh;
      if (wr_stb && hit(addr, REG_MASK_ONE)) mask_one <= next_sh;
      if (wr_stb && hit(addr, REG_MASK_TWO)) mask_two <= next_sh;
      if (wr_stb && hit(addr, REG_BPV_LOW)) bpv_low_stage <= next_sh;
      if (wr_stb && hit(addr, REG_BPV_HIGH)) bpv_count <= {next_sh, bpv_low_stage};
    end
  end

  // ----------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------
  wire fe_kind_ok = esf ? (i_frm.fbit_kind == FB_ESF) : ((i_frm.fbit_kind == FB_TERMINAL) |
    ((i_frm.fbit_kind == FB_SIGNALING) & o_rx_ctrl_one[CTL_SIG_FRAME_ERR]));
  wire fe_ev = i_frm.fbit_valid & i_frm.fbit_err & fe_kind_ok;
  wire auto_clear = rd_done & o_rx_ctrl_one[CTL_AUTO_RESET];
  wire [2:0] cnt_event = {fe_ev, i_frm.oof_event, i_frm.crc_error};
  wire [2:0] cnt_clear = {auto_clear, auto_clear, auto_clear | ~esf};
  wire [2:0] cnt_load = {wr_stb & hit(addr, REG_FE), wr_stb & hit(addr, REG_OOF), wr_stb & hit(addr, REG_CRC)};
  wire [7:0] cnt_value [0:2];
  wire [2:0] cnt_ovf;

  generate
    for (genvar i = 0; i < 3; i++) begin : g_cnt
      tem_sat_counter u_cnt (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_clear(cnt_clear[i]),
        .i_load(cnt_load[i]),
        .i_load_value(next_sh),
        .i_hold(i_frm.sync_loss),
        .i_event(cnt_event[i]),
        .o_count(cnt_value[i]),
        .o_overflow(cnt_ovf[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Line monitor and yellow alarm
  // ----------------------------------------------------------------
  wire zero8;
  wire zero16;
  wire carrier_loss;
  wire ais;
  wire b8zs_word;

  tem_line_monitor #(.AIS_WINDOW(AIS_WINDOW)) u_line (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_bit_stb(bit_stb),
    .i_pos(pin_s2[1]),
    .i_neg(pin_s2[0]),
    .o_zero8(zero8),
    .o_zero16(zero16),
    .o_carrier_loss(carrier_loss),
    .o_ais(ais),
    .o_b8zs_word(b8zs_word)
  );

  logic [8:0] yel_run;
  wire yel_sbit_mode = ~esf & o_rx_ctrl_two[CTL_YEL_SOURCE];

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      yel_run <= 9'h000;
      o_yellow_alarm_flag <= 1'b0;
    end else if (esf) begin
      if (i_frm.fdl_valid && i_frm.fdl_is_00ff) begin
        yel_run <= (yel_run == YEL_FDL_LAST) ? yel_run : yel_run + 9'h001;
        if (yel_run == YEL_FDL_LAST) o_yellow_alarm_flag <= 1'b1;
      end else if (i_frm.fdl_valid) begin
        yel_run <= 9'h000;
        o_yellow_alarm_flag <= 1'b0;
      end
    end else if (yel_sbit_mode) begin
      if (i_frm.f12_valid) o_yellow_alarm_flag <= i_frm.f12_sbit;
    end else if (i_frm.chan_valid && !i_frm.chan_bit2) begin
      yel_run <= (yel_run == YEL_CHAN_LAST) ? yel_run : yel_run + 9'h001;
      if (yel_run == YEL_CHAN_LAST) o_yellow_alarm_flag <= 1'b1;
    end else if (i_frm.chan_valid) begin
      yel_run <= 9'h000;
      o_yellow_alarm_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status registers and interrupt
  // ----------------------------------------------------------------
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic cl_prev;
  logic ais_prev;

  // Live conditions feed the set term every cycle, so a read cannot clear an alarm that persists.
  wire [7:0] status_one_set = {zero8, zero16, carrier_loss, o_yellow_alarm_flag,
    i_frm.sync_loss, b8zs_word, ais, i_frm.alignment_change_flag_event};
  wire [7:0] status_two_set = {1'b0, cl_prev & ~carrier_loss, ais_prev & ~ais, fe_ev, cnt_ovf, 1'b0};
  wire status_one_clr = rd_done & ~burst & hit(addr, REG_STATUS_ONE);
  wire status_two_clr = rd_done & ~burst & hit(addr, REG_STATUS_TWO);
  wire int_pending = |((status_one & mask_one) | (status_two & mask_two));

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_one <= RST_REG;
      status_two <= RST_REG;
      cl_prev <= 1'b0;
      ais_prev <= 1'b0;
      o_int_b <= 1'b1;
    end else begin
      cl_prev <= carrier_loss;
      ais_prev <= ais;
      status_one <= (status_one & ~{8{status_one_clr}}) | status_one_set;
      status_two <= (status_two & ~{8{status_two_clr}}) | status_two_set;
      o_int_b <= ~int_pending;
    end
  end

  assign reg_view[REG_BPV_HIGH] = bpv_count[15:8];
  assign reg_view[REG_BPV_LOW] = bpv_count[7:0];
  assign reg_view[REG_CRC] = cnt_value[0];
  assign reg_view[REG_OOF] = cnt_value[1];
  assign reg_view[REG_FE] = cnt_value[2];
  assign reg_view[REG_STATUS_ONE] = status_one;
  assign reg_view[REG_MASK_ONE] = mask_one;
  assign reg_view[REG_STATUS_TWO] = status_two;
  assign reg_view[REG_MASK_TWO] = mask_two;
  assign reg_view[REG_CTRL_ONE] = o_rx_ctrl_one;
  assign reg_view[REG_CTRL_TWO] = o_rx_ctrl_two;
  generate
    for (genvar j = 11; j < 16; j++) begin : g_unmapped
      assign reg_view[j] = RST_REG;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  AST_CRC_ZERO_SF: assert property (!esf |=> cnt_value[0] == 8'h00)
    else $error("crc count not held at zero");
  AST_HOLD_SYNC_LOSS: assert property ((i_frm.sync_loss && !cnt_clear[1] && !cnt_load[1])
    |=> $stable(cnt_value[1]))
    else $error("oof count moved during sync loss");
  AST_CRC_SAT_INT: assert property ((cnt_ovf[0] && mask_two[1]) |-> ##2 !o_int_b)
    else $error("crc overflow gave no interrupt");
  AST_OOF_SAT: assert property (cnt_ovf[1] |=> (cnt_value[1] == CNT_MAX && status_two[2]))
    else $error("oof counter left saturation");
  AST_FE_ESF: assert property ((esf && fe_ev && !i_frm.sync_loss && !cnt_load[2] && !auto_clear
    && cnt_value[2] != CNT_MAX) |=> cnt_value[2] == $past(cnt_value[2]) + 8'h01)
    else $error("framing error not counted");
  AST_FE_SF_SIGNAL: assert property ((!esf && i_frm.fbit_kind == FB_SIGNALING
    && !o_rx_ctrl_one[CTL_SIG_FRAME_ERR] && !i_frm.oof_event && !cnt_load[2] && !auto_clear)
    |=> $stable(cnt_value[2]))
    else $error("signaling error counted while disabled");
  AST_FE_SAT_INT: assert property ((cnt_ovf[2] && mask_two[3]) |=> status_two[3] ##1 !o_int_b)
    else $error("framing overflow gave no interrupt");
  AST_STATUS_LATCH: assert property ((!status_one_clr)
    |=> ((status_one & $past(status_one)) == $past(status_one)))
    else $error("status bit dropped without read");
  AST_INT_SET: assert property (|(status_one & mask_one) |=> !o_int_b)
    else $error("interrupt missing");
  AST_INT_RELEASE: assert property (!int_pending |=> o_int_b)
    else $error("interrupt held without cause");
  AST_YEL_SBIT: assert property ((yel_sbit_mode && i_frm.f12_valid)
    |=> o_yellow_alarm_flag == $past(i_frm.f12_sbit))
    else $error("yellow does not follow frame 12 s-bit");

  COV_CRC_OVERFLOW: cover property (cnt_ovf[0]);
  COV_YELLOW_RISE: cover property ($rose(o_yellow_alarm_flag));
  COV_BURST_READ: cover property (rd_done && burst);
  COV_STATUS_CLEAR: cover property (status_one_clr && |status_one);
endmodule

/* File: tem_pkg.sv */
package tem_pkg;
  localparam int SYS_CLK_MHZ = 200;
  localparam int AIS_WINDOW_US = 3000;
  localparam int AIS_WINDOW_CYCLES = AIS_WINDOW_US * SYS_CLK_MHZ;
  localparam logic [3:0] REG_BPV_HIGH = 4'h0;
  localparam logic [3:0] REG_BPV_LOW = 4'h1;
  localparam logic [3:0] REG_CRC = 4'h2;
  localparam logic [3:0] REG_OOF = 4'h3;
  localparam logic [3:0] REG_FE = 4'h4;
  localparam logic [3:0] REG_STATUS_ONE = 4'h5;
  localparam logic [3:0] REG_MASK_ONE = 4'h6;
  localparam logic [3:0] REG_STATUS_TWO = 4'h7;
  localparam logic [3:0] REG_MASK_TWO = 4'h8;
  localparam logic [3:0] REG_CTRL_ONE = 4'h9;
  localparam logic [3:0] REG_CTRL_TWO = 4'ha;
  localparam int ACB_RW = 0;
  localparam int ACB_BURST = 7;
  localparam int CTL_SIG_FRAME_ERR = 3;
  localparam int CTL_AUTO_RESET = 4;
  localparam int CTL_YEL_SOURCE = 3;
  localparam int CTL_FORMAT = 4;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [5:0] PIN_SYNC_RST = 6'h30;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] ZERO_RUN_EIGHT = 8'h08;
  localparam logic [7:0] ZERO_RUN_SIXTEEN = 8'h10;
  localparam logic [7:0] ZERO_RUN_CARRIER = 8'hc0;
  localparam logic [6:0] CL_BLOCK_LAST = 7'h6f;
  localparam logic [6:0] CL_ONES_MIN = 7'h0e;
  localparam logic [2:0] AIS_ZEROS_MAX = 3'h5;
  localparam logic [8:0] YEL_CHAN_LAST = 9'h0ff;
  localparam logic [8:0] YEL_FDL_LAST = 9'h00f;
  localparam logic [1:0] SYM_ZERO = 2'b00;
  localparam logic [1:0] SYM_POS = 2'b10;
  localparam logic [1:0] SYM_NEG = 2'b01;
  typedef enum logic [1:0] {FB_TERMINAL = 2'b00, FB_SIGNALING = 2'b01, FB_ESF = 2'b10} tem_fbit_type;
  typedef enum logic [1:0] {SP_IDLE = 2'b00, SP_CMD = 2'b01, SP_DATA = 2'b10} tem_sp_state_type;
  typedef struct packed {
    logic fbit_valid;
    tem_fbit_type fbit_kind;
    logic fbit_err;
    logic oof_event;
    logic crc_error;
    logic sync_loss;
    logic alignment_change_flag_event;
    logic chan_valid;
    logic chan_bit2;
    logic f12_valid;
    logic f12_sbit;
    logic fdl_valid;
    logic fdl_is_00ff;
  } tem_frm_type;
endpackage

/* File: tem_sat_counter.sv */
`timescale 1ns/1ps
module tem_sat_counter (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clear,
  input wire logic i_load,
  input wire logic [7:0] i_load_value,
  input wire logic i_hold,
  input wire logic i_event,
  output logic [7:0] o_count,
  output logic o_overflow
);
  import tem_pkg::*;

  wire counting = i_event & ~i_hold & ~i_clear & ~i_load;

  assign o_overflow = counting & (o_count == CNT_MAX);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_count <= RST_REG;
    end else if (i_clear) begin
      o_count <= RST_REG;
    end else if (i_load) begin
      o_count <= i_load_value;
    end else if (counting && o_count != CNT_MAX) begin
      o_count <= o_count + 8'h01;
    end
  end
endmodule

/* File: tem_line_monitor.sv */
`timescale 1ns/1ps
module tem_line_monitor #(
  parameter int AIS_WINDOW = tem_pkg::AIS_WINDOW_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_bit_stb,
  input wire logic i_pos,
  input wire logic i_neg,
  output logic o_zero8,
  output logic o_zero16,
  output logic o_carrier_loss,
  output logic o_ais,
  output logic o_b8zs_word
);
  import tem_pkg::*;

  localparam int WIN_W = $clog2(AIS_WINDOW);

  logic [7:0] zero_run;
  logic [6:0] blk_pos;
  logic [6:0] blk_ones;
  logic [WIN_W-1:0] win_cnt;
  logic [2:0] win_zeros;
  logic [15:0] window;
  logic last_pos;
  logic fresh;

  wire mark = i_pos | i_neg;
  wire [6:0] next_ones = blk_ones + {6'h00, mark};
  wire win_end = (win_cnt == WIN_W'(AIS_WINDOW - 1));
  wire [2:0] next_zeros = (i_bit_stb && !mark && win_zeros != 3'h7) ? win_zeros + 3'h1 : win_zeros;
  wire [1:0] sym_v = last_pos ? SYM_POS : SYM_NEG;
  wire [1:0] sym_b = last_pos ? SYM_NEG : SYM_POS;
  wire b8zs_match = (window == {SYM_ZERO, SYM_ZERO, SYM_ZERO, sym_v, sym_b, SYM_ZERO, sym_b, sym_v});

  assign o_zero8 = (zero_run >= ZERO_RUN_EIGHT);
  assign o_zero16 = (zero_run >= ZERO_RUN_SIXTEEN);
  assign o_b8zs_word = fresh & b8zs_match;

  // The window is counted in system clock cycles so that a stopped line clock still ends it.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      zero_run <= RST_REG;
      blk_pos <= 7'h00;
      blk_ones <= 7'h00;
      o_carrier_loss <= 1'b0;
      win_cnt <= '0;
      win_zeros <= 3'h0;
      o_ais <= 1'b0;
      window <= 16'h0000;
      last_pos <= 1'b0;
      fresh <= 1'b0;
    end else begin
      fresh <= i_bit_stb;
      win_cnt <= win_end ? '0 : win_cnt + WIN_W'(1);
      win_zeros <= win_end ? 3'h0 : next_zeros;
      if (win_end) begin
        o_ais <= (next_zeros <= AIS_ZEROS_MAX);
      end
      if (i_bit_stb) begin
        zero_run <= mark ? RST_REG : ((zero_run == CNT_MAX) ? zero_run : zero_run + 8'h01);
        window <= {window[13:0], i_pos, i_neg};
        if (window[15:14] != SYM_ZERO) begin
          last_pos <= window[15];
        end
        if (blk_pos == CL_BLOCK_LAST) begin
          blk_pos <= 7'h00;
          blk_ones <= 7'h00;
          if (next_ones >= CL_ONES_MIN) begin
            o_carrier_loss <= 1'b0;
          end
        end else begin
          blk_pos <= blk_pos + 7'h01;
          blk_ones <= next_ones;
        end
        if (!mark && zero_run == ZERO_RUN_CARRIER - 8'h01) begin
          o_carrier_loss <= 1'b1;
        end
      end
    end
  end

  AST_ZERO_ONE_CLEARS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_bit_stb && mark) |=> (!o_zero8 && !o_zero16)) else $error("zero flags kept after a one");
  AST_CARRIER_SET: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_bit_stb && !mark && zero_run == ZERO_RUN_CARRIER - 8'h01) |=> o_carrier_loss)
    else $error("carrier loss not set after long zero run");
endmodule

/* File: tem_line_rx_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Line receiver model: alternate mark inversion rails, 64 ns bits
// ----------------------------------------------------------------
module tem_line_rx_model (
  output logic o_rclk,
  output logic o_pos,
  output logic o_neg
);
  logic last_pos;
  initial begin
    o_rclk = 1'b0;
    o_pos = 1'b0;
    o_neg = 1'b0;
    last_pos = 1'b0;
  end
  // The clock stands still between bursts, so idle rail values are never sampled.
  task automatic send(input int n, input logic one);
    for (int i = 0; i < n; i++) begin
      if (one) begin
        last_pos = ~last_pos;
        o_pos = last_pos;
        o_neg = ~last_pos;
      end else begin
        o_pos = 1'b0;
        o_neg = 1'b0;
      end
      #32 o_rclk = 1'b1;
      #32 o_rclk = 1'b0;
    end
    o_pos = ~o_pos;
    o_neg = ~o_neg;
  endtask
  // A zero substitution word: three zeros, violation, pulse, zero, violation, pulse.
  task automatic send_code();
    logic [7:0] mark;
    logic [7:0] viol;
    mark = 8'h1b;
    viol = 8'h12;
    for (int i = 7; i >= 0; i--) begin
      if (mark[i] && !viol[i]) last_pos = ~last_pos;
      o_pos = mark[i] & last_pos;
      o_neg = mark[i] & ~last_pos;
      #32 o_rclk = 1'b1;
      #32 o_rclk = 1'b0;
    end
  endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  import tem_pkg::*;
  localparam int TIMEOUT = 80000;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_cs_b = 1'b1;
  logic i_sclk = 1'b1;
  logic i_sdi = 1'b0;
  logic o_sdo, o_sdo_oe_b, o_yellow_alarm_flag, o_int_b, rclk, rx_positive_rail, rx_negative_rail, sl = 1'b0;
  logic [7:0] o_rx_ctrl_one, o_rx_ctrl_two, rd;
  tem_frm_type frm = '0;
  tem_frm_type frm_bus;
  tem_frm_type f;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  always_comb begin
    frm_bus = frm;
    frm_bus.sync_loss = sl;
  end
  tem_line_rx_model i_tem_line_rx_model (.o_rclk(rclk), .o_pos(rx_positive_rail), .o_neg(rx_negative_rail));
  tem_error_monitor #(.AIS_WINDOW(2000)) i_tem_error_monitor (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_cs_b(i_cs_b), .i_sclk(i_sclk), .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe_b(o_sdo_oe_b), .i_rclk(rclk),
    .i_rx_positive_rail(rx_positive_rail), .i_rx_negative_rail(rx_negative_rail), .i_frm(frm_bus), .o_rx_ctrl_one(o_rx_ctrl_one),
    .o_rx_ctrl_two(o_rx_ctrl_two), .o_yellow_alarm_flag(o_yellow_alarm_flag), .o_int_b(o_int_b));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge i_sys_clk);
    #1;
  endtask
  // Half periods of seven cycles leave room for the pin synchronisers.
  task automatic sp_xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] sh;
    sh = {wd, cmd};
    rdat = 8'h00;
    @(posedge i_sys_clk) i_cs_b <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge i_sys_clk) begin
        i_sclk <= 1'b0;
        i_sdi <= sh[i];
      end
      repeat (6) @(posedge i_sys_clk);
      #1;
      if (i >= 8) rdat[i-8] = o_sdo;
      if (i == 8) chk({7'h00, o_sdo_oe_b}, {7'h00, ~cmd[0]});
      @(posedge i_sys_clk) i_sclk <= 1'b1;
      repeat (6) @(posedge i_sys_clk);
    end
    @(posedge i_sys_clk) i_cs_b <= 1'b1;
    settle();
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    sp_xfer({3'h0, a, 1'b0}, d, dummy);
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    sp_xfer({3'h0, a, 1'b1}, 8'h00, d);
  endtask
  task automatic pulse(input tem_frm_type p, input int n);
    repeat (n) begin
      @(posedge i_sys_clk) frm <= p;
      @(posedge i_sys_clk) frm <= '0;
    end
    settle();
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [3:0] addrs [8] = '{REG_CRC, REG_OOF, REG_FE, REG_MASK_ONE, REG_MASK_TWO, REG_CTRL_ONE, REG_CTRL_TWO, 4'hb};
    chk({7'h00, o_int_b}, 8'h01);
    foreach (addrs[i]) begin
      reg_rd(addrs[i], rd);
      chk(rd, RST_REG);
    end
    reg_wr(REG_BPV_LOW, 8'h34);
    reg_wr(REG_BPV_HIGH, 8'h12);
    reg_rd(REG_BPV_LOW, rd);
    chk(rd, 8'h34);
    reg_rd(REG_BPV_HIGH, rd);
    chk(rd, 8'h12);
  endtask
  task automatic t_crc();
    f = '0;
    f.crc_error = 1'b1;
    pulse(f, 1);
    reg_rd(REG_CRC, rd);
    chk(rd, 8'h00);
    reg_wr(REG_CTRL_TWO, 8'h10);
    chk(o_rx_ctrl_two, 8'h10);
    reg_wr(REG_CRC, 8'hfd);
    pulse(f, 2);
    reg_rd(REG_CRC, rd);
    chk(rd, 8'hff);
    reg_wr(REG_MASK_TWO, 8'h02);
    chk({7'h00, o_int_b}, 8'h01);
    pulse(f, 1);
    chk({7'h00, o_int_b}, 8'h00);
    reg_rd(REG_STATUS_TWO, rd);
    chk(rd & 8'h02, 8'h02);
    reg_rd(REG_STATUS_TWO, rd);
    chk(rd & 8'h02, 8'h00);
    chk({7'h00, o_int_b}, 8'h01);
    reg_rd(REG_CRC, rd);
    chk(rd, 8'hff);
  endtask
  task automatic t_sync();
    @(posedge i_sys_clk) sl <= 1'b1;
    f = '0;
    f.oof_event = 1'b1;
    pulse(f, 1);
    reg_rd(REG_OOF, rd);
    chk(rd, 8'h00);
    reg_rd(REG_STATUS_ONE, rd);
    chk(rd & 8'h08, 8'h08);
    @(posedge i_sys_clk) sl <= 1'b0;
    pulse(f, 1);
    reg_rd(REG_OOF, rd);
    chk(rd, 8'h01);
    reg_wr(REG_OOF, 8'hff);
    pulse(f, 1);
    reg_rd(REG_STATUS_TWO, rd);
    chk(rd & 8'h04, 8'h04);
    reg_rd(REG_OOF, rd);
    chk(rd, 8'hff);
  endtask
  task automatic t_frame();
    f = '0;
    f.fbit_valid = 1'b1;
    f.fbit_err = 1'b1;
    f.fbit_kind = FB_ESF;
    pulse(f, 1);
    reg_rd(REG_FE, rd);
    chk(rd, 8'h01);
    reg_wr(REG_CTRL_TWO, 8'h00);
    f.fbit_kind = FB_SIGNALING;
    pulse(f, 1);
    reg_rd(REG_FE, rd);
    chk(rd, 8'h01);
    reg_wr(REG_CTRL_ONE, 8'h08);
    chk(o_rx_ctrl_one, 8'h08);
    pulse(f, 1);
    f.fbit_kind = FB_TERMINAL;
    pulse(f, 1);
    reg_rd(REG_FE, rd);
    chk(rd, 8'h03);
    reg_wr(REG_FE, 8'hff);
    reg_wr(REG_MASK_TWO, 8'h08);
    pulse(f, 1);
    chk({7'h00, o_int_b}, 8'h00);
    reg_rd(REG_STATUS_TWO, rd);
    chk(rd & 8'h18, 8'h18);
    reg_wr(REG_MASK_TWO, 8'h00);
    reg_wr(REG_CTRL_ONE, 8'h18);
    reg_rd(REG_FE, rd);
    chk(rd, 8'hff);
    reg_rd(REG_FE, rd);
    chk(rd, 8'h00);
    reg_wr(REG_CTRL_ONE, 8'h08);
  endtask
  task automatic t_alignment_change_flag();
    f = '0;
    f.alignment_change_flag_event = 1'b1;
    pulse(f, 1);
    chk({7'h00, o_int_b}, 8'h01);
    reg_wr(REG_MASK_ONE, 8'h01);
    chk({7'h00, o_int_b}, 8'h00);
    reg_rd(REG_STATUS_ONE, rd);
    chk(rd & 8'h01, 8'h01);
    chk({7'h00, o_int_b}, 8'h01);
    reg_wr(REG_MASK_ONE, 8'h00);
  endtask
  task automatic t_line();
    i_tem_line_rx_model.send(16, 1'b0);
    reg_rd(REG_STATUS_ONE, rd);
    chk(rd & 8'hc0, 8'hc0);
    i_tem_line_rx_model.send(1, 1'b1);
    reg_rd(REG_STATUS_ONE, rd);
    reg_rd(REG_STATUS_ONE, rd);
    chk(rd & 8'hc0, 8'h00);
    i_tem_line_rx_model.send(192, 1'b0);
    reg_rd(REG_STATUS_ONE, rd);
    chk(rd & 8'h20, 8'h20);
    i_tem_line_rx_model.send(352, 1'b1);
    reg_rd(REG_STATUS_TWO, rd);
    chk(rd & 8'h40, 8'h40);
    reg_rd(REG_STATUS_ONE, rd);
    reg_rd(REG_STATUS_ONE, rd);
    chk(rd & 8'h22, 8'h02);
    i_tem_line_rx_model.send_code();
    reg_rd(REG_STATUS_ONE, rd);
    chk(rd & 8'h04, 8'h04);
    i_tem_line_rx_model.send(200, 1'b0);
    reg_rd(REG_STATUS_TWO, rd);
    chk(rd & 8'h20, 8'h20);
  endtask
  task automatic t_yellow();
    f = '0;
    f.chan_valid = 1'b1;
    pulse(f, 255);
    chk({7'h00, o_yellow_alarm_flag}, 8'h00);
    pulse(f, 1);
    chk({7'h00, o_yellow_alarm_flag}, 8'h01);
    f.chan_bit2 = 1'b1;
    pulse(f, 1);
    chk({7'h00, o_yellow_alarm_flag}, 8'h00);
    reg_wr(REG_CTRL_TWO, 8'h08);
    f = '0;
    f.f12_valid = 1'b1;
    f.f12_sbit = 1'b1;
    pulse(f, 1);
    chk({7'h00, o_yellow_alarm_flag}, 8'h01);
    f.f12_sbit = 1'b0;
    pulse(f, 1);
    chk({7'h00, o_yellow_alarm_flag}, 8'h00);
    reg_wr(REG_CTRL_TWO, 8'h10);
    f = '0;
    f.fdl_valid = 1'b1;
    f.fdl_is_00ff = 1'b1;
    pulse(f, 15);
    chk({7'h00, o_yellow_alarm_flag}, 8'h00);
    pulse(f, 1);
    chk({7'h00, o_yellow_alarm_flag}, 8'h01);
    f.fdl_is_00ff = 1'b0;
    pulse(f, 1);
    chk({7'h00, o_yellow_alarm_flag}, 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    settle();
    t_reset();
    t_crc();
    t_sync();
    t_frame();
    t_alignment_change_flag();
    t_line();
    t_yellow();
    final_report();
  end
endmodule
